/* File: hw/itbu_pkg.sv */
/*
 * Package for the interrupt and time-base unit: APB register offsets, field
 * positions, reset values, source indices and interrupt vector codes.
 * Assumes a 32-bit APB with one register per aligned word.
 */
package itbu_pkg;

    // Register byte offsets
    localparam logic [7:0] ITBU_OFF_PSC0     = 8'h00;
    localparam logic [7:0] ITBU_OFF_PSC1     = 8'h04;
    localparam logic [7:0] ITBU_OFF_TBC0     = 8'h08;
    localparam logic [7:0] ITBU_OFF_TBC1     = 8'h0C;
    localparam logic [7:0] ITBU_OFF_ENABLE   = 8'h10;
    localparam logic [7:0] ITBU_OFF_FLAGS    = 8'h14;
    localparam logic [7:0] ITBU_OFF_FLAG_CLR = 8'h18;
    localparam logic [7:0] ITBU_OFF_FLAG_SET = 8'h1C;
    localparam logic [7:0] ITBU_OFF_STATUS   = 8'h20;

    // Field positions
    localparam int ITBU_TB_ON_BIT   = 7;
    localparam int ITBU_TB_PER_MSB  = 2;
    localparam int ITBU_SRC_MSB     = 1;
    localparam int ITBU_GIE_BIT     = 15;

    // Reset values
    localparam logic [1:0]  ITBU_SRC_RST    = 2'h0;
    localparam logic [7:0]  ITBU_TBC_RST    = 8'h00;
    localparam logic [15:0] ITBU_EN_RST     = 16'h0000;
    localparam logic [13:0] ITBU_FLAG_RST   = 14'h0000;

    // Prescaler source codes
    localparam logic [1:0] ITBU_SRC_SYS     = 2'h0;
    localparam logic [1:0] ITBU_SRC_SYS4    = 2'h1;

    // Timing counts
    localparam int ITBU_TB_MIN_EXP   = 8;
    localparam int ITBU_TB_CNT_W     = 16;
    localparam logic [1:0] ITBU_DIV4_LAST = 2'h3;

    // Request-flag indices (order is also the priority order, 0 highest)
    localparam int ITBU_NSRC   = 14;
    localparam int ITBU_F_SER  = 0;
    localparam int ITBU_F_UART = 1;
    localparam int ITBU_F_TB0  = 2;
    localparam int ITBU_F_TB1  = 3;
    localparam int ITBU_F_MF0  = 4;
    localparam int ITBU_F_MF1  = 5;
    localparam int ITBU_F_MF2  = 6;
    localparam int ITBU_F_T0A  = 7;
    localparam int ITBU_F_T0P  = 8;
    localparam int ITBU_F_T1A  = 9;
    localparam int ITBU_F_T1P  = 10;
    localparam int ITBU_F_LV   = 11;
    localparam int ITBU_F_NV   = 12;
    localparam int ITBU_F_SPR  = 13;

    // Vector codes
    localparam logic [2:0] ITBU_VEC_SER  = 3'h0;
    localparam logic [2:0] ITBU_VEC_UART = 3'h1;
    localparam logic [2:0] ITBU_VEC_TB0  = 3'h2;
    localparam logic [2:0] ITBU_VEC_TB1  = 3'h3;
    localparam logic [2:0] ITBU_VEC_MF0  = 3'h4;
    localparam logic [2:0] ITBU_VEC_MF1  = 3'h5;
    localparam logic [2:0] ITBU_VEC_MF2  = 3'h6;

endpackage

/* File: hw/itbu_timebase.sv */
/*
 * One time-base generator: prescaler source select, free-running counter
 * and an overflow pulse at 2^(8+period) prescaler clocks.
 * Assumes the sub clock tick is already synchronised to i_mclk.
 */
`timescale 1ns/100ps
module itbu_timebase #(
    parameter int CNT_W = itbu_pkg::ITBU_TB_CNT_W
) (
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic [1:0] i_source,
    input  wire logic       i_on,
    input  wire logic [2:0] i_period,
    input  wire logic       i_sub_tick,
    output logic            o_overflow
);

    logic [1:0]       div4_reg;
    logic             tick;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] mask;

    // Divide by four of the system clock
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div4_reg <= 2'h0;
        end else begin
            div4_reg <= div4_reg + 2'h1;
        end
    end

    // Source select
    always_comb begin
        if (i_source[1]) begin
            tick = i_sub_tick;
        end else if (i_source == itbu_pkg::ITBU_SRC_SYS4) begin
            tick = (div4_reg == itbu_pkg::ITBU_DIV4_LAST);
        end else begin
            tick = 1'b1;
        end
    end

    // Period mask 2^(8+code)-1
    assign mask = CNT_W'((32'h1 << (itbu_pkg::ITBU_TB_MIN_EXP + 32'(i_period))) - 32'h1);

    // Counter runs while on, held at zero while off
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count_reg <= '0;
        end else if (!i_on) begin
            count_reg <= '0;
        end else if (tick) begin
            count_reg <= count_reg + CNT_W'(1);
        end
    end

    // Overflow when the selected low bits wrap
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_overflow <= 1'b0;
        end else begin
            o_overflow <= i_on && tick && ((count_reg & mask) == mask);
        end
    end

endmodule // itbu_timebase

/* File: hw/itbu_top.sv */
/*
 * Interrupt and time-base unit: two time-base generators, request flags,
 * multi-function grouping, priority vectoring, return handling and wake-up.
 * Assumes APB master on i_mclk, core handshake on i_mclk, peripheral event
 * inputs as one-cycle pulses on i_mclk, and the sub clock tick arriving
 * asynchronously as a level toggled by the sub oscillator.
 */
//
// Function
// - Second prescaler source: 00 system, 01 system/4, 1x sub clock.
// - First time-base control bit 7 enables generator zero; resets to zero.
// - Generator zero period is 2^(8+code) first-prescaler clocks.
// - Second time-base control bit 7 enables generator one; resets zero.
// - Generator one period is 2^(8+code) second-prescaler clocks.
// - Unimplemented control bits ignore writes and read zero.
// - Each timer has compare A and P flags feeding a group.
// - Timer request vectors only with global, own and group enables.
// - Grouped timer service clears global enable and group flag only.
// - Serial flag set on byte done, address match or bus time-out.
// - Serial service clears its flag and global enable; needs both enables.
// - UART request raised on any of six transfer conditions.
// - UART service clears its flag and global enable; needs both enables.
// - Low-supply flag sets on detect, grouped, needs three enables.
// - Low-supply service clears group flag and global enable only.
// - Write-done flag sets on cycle end; grouped; not auto-cleared.
// - Any flag rising wakes from sleep or idle regardless of enables.
// - A set flag stays set until serviced or cleared by software.
// - Vectoring only while the return stack is not full.
// - Entry pushes only the program counter.
// - Return-from-irq pops and sets global enable; plain return leaves it.
// - First prescaler source: 00 system, 01 system/4, 1x sub clock.
// - Time-base overflow sets its flag; service clears flag and global enable.
// - Group flag sets whenever any member flag becomes set.
`timescale 1ns/100ps
module itbu_top (
    input  wire logic        i_mclk,
    input  wire logic        i_arst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Sub clock tick level (asynchronous)
    input  wire logic        i_sub_clock,
    // Peripheral events, one-cycle pulses
    input  wire logic [5:0]  i_serial_events,
    input  wire logic [5:0]  i_uart_events,
    input  wire logic        i_timer0_match_a,
    input  wire logic        i_timer0_match_p,
    input  wire logic        i_timer1_match_a,
    input  wire logic        i_timer1_match_p,
    input  wire logic        i_low_supply,
    input  wire logic        i_nv_write_done,
    // Processor core
    input  wire logic        i_stack_full,
    input  wire logic        i_irq_ack,
    input  wire logic        i_return_from_irq,
    input  wire logic        i_return_plain,
    output logic             o_irq_req,
    output logic [2:0]       o_irq_vector,
    output logic             o_push_pc,
    output logic             o_pop_pc,
    output logic             o_wake
);

    localparam int N = itbu_pkg::ITBU_NSRC;

    logic [1:0]   psc0_src_reg;
    logic [1:0]   psc1_src_reg;
    logic [7:0]   tbc0_reg;
    logic [7:0]   tbc1_reg;
    logic [15:0]  enable_reg;
    logic [N-1:0] flags_reg;
    logic [N-1:0] flags_next;
    logic [N-1:0] set_evt;
    logic [N-1:0] clr_sw;
    logic [N-1:0] clr_svc;
    logic [N-1:0] prev_flags_reg;
    logic         gie_reg;
    logic [2:0]   sub_sync_reg;
    logic         sub_tick;
    logic         tb0_ovf;
    logic         tb1_ovf;
    logic         wr_en;
    logic         rd_en;
    logic         addr_ok;
    logic [6:0]   grp_pend;
    logic         pending;
    logic [2:0]   win_vec;

    // Bit position of a register field within 32-bit write data
    function automatic logic bit_of(input logic [31:0] d, input int pos);
        bit_of = d[pos];
    endfunction

    // Address decode used only for the slave error response
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == itbu_pkg::ITBU_OFF_PSC0) || (a == itbu_pkg::ITBU_OFF_PSC1) ||
                    (a == itbu_pkg::ITBU_OFF_TBC0) || (a == itbu_pkg::ITBU_OFF_TBC1) ||
                    (a == itbu_pkg::ITBU_OFF_ENABLE) || (a == itbu_pkg::ITBU_OFF_FLAGS) ||
                    (a == itbu_pkg::ITBU_OFF_FLAG_CLR) || (a == itbu_pkg::ITBU_OFF_FLAG_SET) ||
                    (a == itbu_pkg::ITBU_OFF_STATUS);
    endfunction

    // APB answers in the first access cycle
    assign o_pready  = 1'b1;
    assign addr_ok   = is_mapped(i_paddr);
    assign wr_en     = i_psel && i_penable && i_pwrite;
    assign rd_en     = i_psel && !i_pwrite;
    assign o_pslverr = i_psel && i_penable && !addr_ok;

    // Sub clock synchroniser and edge pulse
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sub_sync_reg <= 3'h0;
        end else begin
            sub_sync_reg <= {sub_sync_reg[1:0], i_sub_clock};
        end
    end
    assign sub_tick = sub_sync_reg[1] && !sub_sync_reg[2];

    // Prescaler source registers, two bits implemented
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            psc0_src_reg <= itbu_pkg::ITBU_SRC_RST;
            psc1_src_reg <= itbu_pkg::ITBU_SRC_RST;
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_PSC0) begin
            psc0_src_reg <= i_pwdata[itbu_pkg::ITBU_SRC_MSB:0];
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_PSC1) begin
            psc1_src_reg <= i_pwdata[itbu_pkg::ITBU_SRC_MSB:0];
        end
    end

    // Time-base control registers keep only bit 7 and bits 2..0
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tbc0_reg <= itbu_pkg::ITBU_TBC_RST;
            tbc1_reg <= itbu_pkg::ITBU_TBC_RST;
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_TBC0) begin
            tbc0_reg <= {bit_of(i_pwdata, itbu_pkg::ITBU_TB_ON_BIT), 4'h0,
                         i_pwdata[itbu_pkg::ITBU_TB_PER_MSB:0]};
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_TBC1) begin
            tbc1_reg <= {bit_of(i_pwdata, itbu_pkg::ITBU_TB_ON_BIT), 4'h0,
                         i_pwdata[itbu_pkg::ITBU_TB_PER_MSB:0]};
        end
    end

    // Generator zero on the first prescaler
    itbu_timebase u_tb0 (
        .i_mclk     (i_mclk),
        .i_arst_n   (i_arst_n),
        .i_source   (psc0_src_reg),
        .i_on       (tbc0_reg[itbu_pkg::ITBU_TB_ON_BIT]),
        .i_period   (tbc0_reg[itbu_pkg::ITBU_TB_PER_MSB:0]),
        .i_sub_tick (sub_tick),
        .o_overflow (tb0_ovf)
    );

    // Generator one on the second prescaler
    itbu_timebase u_tb1 (
        .i_mclk     (i_mclk),
        .i_arst_n   (i_arst_n),
        .i_source   (psc1_src_reg),
        .i_on       (tbc1_reg[itbu_pkg::ITBU_TB_ON_BIT]),
        .i_period   (tbc1_reg[itbu_pkg::ITBU_TB_PER_MSB:0]),
        .i_sub_tick (sub_tick),
        .o_overflow (tb1_ovf)
    );

    // Enable register: one bit per flag index, global enable kept apart
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enable_reg <= itbu_pkg::ITBU_EN_RST;
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_ENABLE) begin
            enable_reg <= {2'h0, i_pwdata[N-1:0]};
        end
    end

    // Hardware set events per flag
    always_comb begin
        set_evt = '0;
        set_evt[itbu_pkg::ITBU_F_SER]  = |i_serial_events;
        set_evt[itbu_pkg::ITBU_F_UART] = |i_uart_events;
        set_evt[itbu_pkg::ITBU_F_TB0]  = tb0_ovf;
        set_evt[itbu_pkg::ITBU_F_TB1]  = tb1_ovf;
        set_evt[itbu_pkg::ITBU_F_T0A]  = i_timer0_match_a;
        set_evt[itbu_pkg::ITBU_F_T0P]  = i_timer0_match_p;
        set_evt[itbu_pkg::ITBU_F_T1A]  = i_timer1_match_a;
        set_evt[itbu_pkg::ITBU_F_T1P]  = i_timer1_match_p;
        set_evt[itbu_pkg::ITBU_F_LV]   = i_low_supply;
        set_evt[itbu_pkg::ITBU_F_NV]   = i_nv_write_done;
        // Group flags set when a member flag rises
        set_evt[itbu_pkg::ITBU_F_MF0]  = (flags_reg[itbu_pkg::ITBU_F_T0A] && !prev_flags_reg[itbu_pkg::ITBU_F_T0A]) ||
                                         (flags_reg[itbu_pkg::ITBU_F_T0P] && !prev_flags_reg[itbu_pkg::ITBU_F_T0P]);
        set_evt[itbu_pkg::ITBU_F_MF1]  = (flags_reg[itbu_pkg::ITBU_F_T1A] && !prev_flags_reg[itbu_pkg::ITBU_F_T1A]) ||
                                         (flags_reg[itbu_pkg::ITBU_F_T1P] && !prev_flags_reg[itbu_pkg::ITBU_F_T1P]);
        set_evt[itbu_pkg::ITBU_F_MF2]  = (flags_reg[itbu_pkg::ITBU_F_LV] && !prev_flags_reg[itbu_pkg::ITBU_F_LV]) ||
                                         (flags_reg[itbu_pkg::ITBU_F_NV] && !prev_flags_reg[itbu_pkg::ITBU_F_NV]);
        if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_FLAG_SET) begin
            set_evt = set_evt | i_pwdata[N-1:0];
        end
    end

    // Member flags gated by own enable, grouped by group enable
    always_comb begin
        grp_pend = '0;
        grp_pend[0] = flags_reg[itbu_pkg::ITBU_F_SER]  && enable_reg[itbu_pkg::ITBU_F_SER];
        grp_pend[1] = flags_reg[itbu_pkg::ITBU_F_UART] && enable_reg[itbu_pkg::ITBU_F_UART];
        grp_pend[2] = flags_reg[itbu_pkg::ITBU_F_TB0]  && enable_reg[itbu_pkg::ITBU_F_TB0];
        grp_pend[3] = flags_reg[itbu_pkg::ITBU_F_TB1]  && enable_reg[itbu_pkg::ITBU_F_TB1];
        grp_pend[4] = flags_reg[itbu_pkg::ITBU_F_MF0]  && enable_reg[itbu_pkg::ITBU_F_MF0] &&
                      ((flags_reg[itbu_pkg::ITBU_F_T0A] && enable_reg[itbu_pkg::ITBU_F_T0A]) ||
                       (flags_reg[itbu_pkg::ITBU_F_T0P] && enable_reg[itbu_pkg::ITBU_F_T0P]));
        grp_pend[5] = flags_reg[itbu_pkg::ITBU_F_MF1]  && enable_reg[itbu_pkg::ITBU_F_MF1] &&
                      ((flags_reg[itbu_pkg::ITBU_F_T1A] && enable_reg[itbu_pkg::ITBU_F_T1A]) ||
                       (flags_reg[itbu_pkg::ITBU_F_T1P] && enable_reg[itbu_pkg::ITBU_F_T1P]));
        grp_pend[6] = flags_reg[itbu_pkg::ITBU_F_MF2]  && enable_reg[itbu_pkg::ITBU_F_MF2] &&
                      ((flags_reg[itbu_pkg::ITBU_F_LV] && enable_reg[itbu_pkg::ITBU_F_LV]) ||
                       (flags_reg[itbu_pkg::ITBU_F_NV] && enable_reg[itbu_pkg::ITBU_F_NV]));
    end

    // Fixed priority, lowest index wins
    always_comb begin
        win_vec = itbu_pkg::ITBU_VEC_MF2;
        for (int k = 6; k >= 0; k--) begin
            if (grp_pend[k]) begin
                win_vec = 3'(k);
            end
        end
    end

    // Request to the core
    assign pending   = (|grp_pend) && gie_reg && !i_stack_full;
    assign o_irq_req = pending;
    assign o_push_pc = pending && i_irq_ack;
    assign o_pop_pc  = i_return_from_irq || i_return_plain;

    // Vector flop loads the winner every cycle, the MF2 code while none pending
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq_vector <= itbu_pkg::ITBU_VEC_SER;
        end else begin
            o_irq_vector <= win_vec;
        end
    end

    // Service clears: own flag for direct vectors, group flag only for groups
    always_comb begin
        clr_svc = '0;
        if (pending && i_irq_ack) begin
            case (o_irq_vector)
                itbu_pkg::ITBU_VEC_SER:  clr_svc[itbu_pkg::ITBU_F_SER]  = 1'b1;
                itbu_pkg::ITBU_VEC_UART: clr_svc[itbu_pkg::ITBU_F_UART] = 1'b1;
                itbu_pkg::ITBU_VEC_TB0:  clr_svc[itbu_pkg::ITBU_F_TB0]  = 1'b1;
                itbu_pkg::ITBU_VEC_TB1:  clr_svc[itbu_pkg::ITBU_F_TB1]  = 1'b1;
                itbu_pkg::ITBU_VEC_MF0:  clr_svc[itbu_pkg::ITBU_F_MF0]  = 1'b1;
                itbu_pkg::ITBU_VEC_MF1:  clr_svc[itbu_pkg::ITBU_F_MF1]  = 1'b1;
                itbu_pkg::ITBU_VEC_MF2:  clr_svc[itbu_pkg::ITBU_F_MF2]  = 1'b1;
                default:                 clr_svc = '0;
            endcase
        end
    end

    // Software clear through write-one-to-clear
    assign clr_sw = (wr_en && i_paddr == itbu_pkg::ITBU_OFF_FLAG_CLR) ? i_pwdata[N-1:0] : '0;

    // Flags are sticky; set wins over any clear
    assign flags_next = (flags_reg & ~(clr_sw | clr_svc)) | set_evt;

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags_reg      <= itbu_pkg::ITBU_FLAG_RST;
            prev_flags_reg <= itbu_pkg::ITBU_FLAG_RST;
        end else begin
            flags_reg      <= flags_next;
            prev_flags_reg <= flags_reg;
        end
    end

    // Global enable: cleared on entry, set by return-from-irq or software
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gie_reg <= 1'b0;
        end else if (pending && i_irq_ack) begin
            gie_reg <= 1'b0;
        end else if (i_return_from_irq) begin
            gie_reg <= 1'b1;
        end else if (wr_en && i_paddr == itbu_pkg::ITBU_OFF_ENABLE) begin
            gie_reg <= bit_of(i_pwdata, itbu_pkg::ITBU_GIE_BIT);
        end
    end

    // Wake on any flag rising, enables ignored
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= |(flags_next & ~flags_reg);
        end
    end

    // Read data mux, unmapped reads zero
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_en && !i_penable) begin
            case (i_paddr)
                itbu_pkg::ITBU_OFF_PSC0:   o_prdata <= {30'h0000_0000, psc0_src_reg};
                itbu_pkg::ITBU_OFF_PSC1:   o_prdata <= {30'h0000_0000, psc1_src_reg};
                itbu_pkg::ITBU_OFF_TBC0:   o_prdata <= {24'h00_0000, tbc0_reg};
                itbu_pkg::ITBU_OFF_TBC1:   o_prdata <= {24'h00_0000, tbc1_reg};
                itbu_pkg::ITBU_OFF_ENABLE: o_prdata <= {16'h0000, gie_reg, enable_reg[14:0]};
                itbu_pkg::ITBU_OFF_FLAGS:  o_prdata <= {18'h0_0000, flags_reg};
                itbu_pkg::ITBU_OFF_STATUS: o_prdata <= {28'h000_0000, pending, win_vec};
                default:                   o_prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // itbu_top

/* File: verification/itbu_monitor.sv */
/* Checker for itbu_top: APB answers, interrupt entry and return strobes.
   Assumes one clock domain; sees only the ports of itbu_top. */
`timescale 1ns/100ps
module itbu_monitor (
    input wire logic        i_mclk,
    input wire logic        i_arst_n,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        i_stack_full,
    input wire logic        i_irq_ack,
    input wire logic        i_return_from_irq,
    input wire logic        i_return_plain,
    input wire logic        o_irq_req,
    input wire logic        o_push_pc,
    input wire logic        o_pop_pc
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // Core strobes follow request, acknowledge and returns
    chk_push_taken: assert property (o_push_pc == (o_irq_req && i_irq_ack))
        else $error("push strobe wrong");
    chk_pop_return: assert property (o_pop_pc == (i_return_from_irq || i_return_plain))
        else $error("pop strobe wrong");
    chk_stack_block: assert property (i_stack_full |-> !o_irq_req)
        else $error("request while stack full");
    chk_entry_mask: assert property (o_irq_req && i_irq_ack && !i_return_from_irq && !i_psel |=> !o_irq_req)
        else $error("request left after entry");
    // Register accesses
    chk_bad_addr: assert property (i_psel && i_penable && i_paddr > 8'h20 |-> o_pslverr)
        else $error("unmapped access not flagged");
    chk_rdata_hold: assert property (i_psel && i_penable |=> $stable(o_prdata))
        else $error("read data moved");
    chk_tbc_zero: assert property (i_psel && i_penable && !i_pwrite && i_paddr inside {8'h08, 8'h0C}
        |-> o_prdata[31:8] == 24'h0 && o_prdata[6:3] == 4'h0)
        else $error("time-base control spare bits set");
    chk_src_zero: assert property (i_psel && i_penable && !i_pwrite && i_paddr inside {8'h00, 8'h04}
        |-> o_prdata[31:2] == 30'h0)
        else $error("source select spare bits set");
endmodule // itbu_monitor
bind itbu_top itbu_monitor u_mon (.i_mclk, .i_arst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata,
    .o_pslverr, .i_stack_full, .i_irq_ack, .i_return_from_irq, .i_return_plain, .o_irq_req, .o_push_pc, .o_pop_pc);

/* File: verification/itbu_core_model.sv */
/* Core stand-in: takes interrupt entry once the request has shown a cycle.
   Assumes the bench can hold entry off to make it answer slowly. */
`timescale 1ns/100ps
module itbu_core_model (
    input  wire logic i_mclk,
    input  wire logic i_arst_n,
    input  wire logic i_irq_req,
    input  wire logic i_hold,
    output logic      o_irq_ack
);
    logic seen_reg;
    // Request seen a full cycle, so the vector has settled
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) seen_reg <= 1'b0;
        else seen_reg <= i_irq_req && !o_irq_ack;
    end
    // Entry pulse
    assign o_irq_ack = i_irq_req && seen_reg && !i_hold;
endmodule // itbu_core_model

/* File: verification/itbu_top_test.sv */
/* Testbench for itbu_top: registers, time bases, vectoring, wake-up.
   Assumes itbu_core_model as the core and the bound itbu_monitor. */
`timescale 1ns/100ps
module itbu_top_test;
    logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pw = 0, sub = 0, full = 0, hold = 0, rfi = 0, ret = 0;
    logic [7:0]  pa = '0;
    logic [31:0] pwd = '0, prdata;
    logic [17:0] ev = '0;
    logic        pready, err, req, ack, push, wake;
    logic [2:0]  vec;
    int          error_cnt = 0, comparisons = 0, cyc = 0;
    localparam logic [7:0] EN = itbu_pkg::ITBU_OFF_ENABLE, FL = itbu_pkg::ITBU_OFF_FLAGS;
    localparam logic [7:0] CLR = itbu_pkg::ITBU_OFF_FLAG_CLR;
    // Clocks: 20 MHz system, 600 ns sub clock
    initial forever #25 clk = ~clk;
    initial begin #7; forever #300 sub = ~sub; end
    always @(posedge clk) cyc <= cyc + 1;
    itbu_top dut (.i_mclk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pw), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(err), .i_sub_clock(sub),
        .i_serial_events(ev[5:0]), .i_uart_events(ev[11:6]), .i_timer0_match_a(ev[12]),
        .i_timer0_match_p(ev[13]), .i_timer1_match_a(ev[14]), .i_timer1_match_p(ev[15]), .i_low_supply(ev[16]),
        .i_nv_write_done(ev[17]), .i_stack_full(full), .i_irq_ack(ack), .i_return_from_irq(rfi),
        .i_return_plain(ret), .o_irq_req(req), .o_irq_vector(vec), .o_push_pc(push), .o_pop_pc(), .o_wake(wake));
    itbu_core_model core (.i_mclk(clk), .i_arst_n(rst_n), .i_irq_req(req), .i_hold(hold), .o_irq_ack(ack));
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n = 0;
        @(posedge clk);
        {psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        r = prdata;
        {psel, pen} <= 2'b00;
        if (n >= 50) error_cnt++;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask
    task automatic pls(input logic [17:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= '0;
    endtask
    // Wait for a wake pulse; give the cycle it came in
    task automatic ww(output int c);
        int n = 0;
        do begin @(negedge clk); n++; end while (wake !== 1'b1 && n < 4000);
        if (n >= 4000) error_cnt++;
        c = cyc;
    endtask
    // Wait for interrupt entry and check its vector
    task automatic wp(input logic [2:0] v);
        int n = 0;
        do begin @(negedge clk); n++; end while (push !== 1'b1 && n < 20);
        chk({push, vec}, {1'b1, v});
    endtask
    task automatic wk(input logic [17:0] v, input logic exp);
        int n = 0;
        repeat (3) @(posedge clk);
        pls(v);
        repeat (4) begin @(negedge clk); if (wake === 1'b1) n++; end
        chk(n != 0, exp);
    endtask
    task automatic t_reg();
        logic [7:0] a;
        for (int i = 0; i < 4; i++) begin
            a = itbu_pkg::ITBU_OFF_PSC0 + 8'(4 * i);
            rd(a, 32'h0);
            wr(a, 32'hFFFF_FFFF);
            rd(a, i < 2 ? 32'h3 : 32'h87);
            wr(a, 32'h0);
        end
        rd(8'h40, 32'h0);
        chk(err, 1'b1);
    endtask
    // Gap between two overflows of one generator
    task automatic t_base(input logic [7:0] ps, input logic [1:0] src, input logic [7:0] tb, input logic [7:0] ctl,
        input int exp);
        int t0, t1;
        wr(ps, {30'h0, src});
        wr(tb, {24'h0, ctl});
        ww(t0);
        wr(CLR, 32'hFFFF);
        ww(t0);
        wr(CLR, 32'hFFFF);
        ww(t1);
        chk(t1 - t0, exp);
        wr(tb, 32'h0);
        wr(CLR, 32'hFFFF);
    endtask
    task automatic t_irq();
        for (int k = 0; k < 6; k++) begin
            pls(18'h1 << k);
            pls(18'h40 << k);
            rd(FL, 32'h3);
            wr(CLR, 32'hFFFF);
        end
        wr(EN, 32'h8003);
        hold <= 1'b1;
        pls(18'h41);
        repeat (3) @(negedge clk);
        chk({req, vec}, 4'h8);
        @(posedge clk) hold <= 1'b0;
        wp(3'h0);
        rd(FL, 32'h2);
        @(negedge clk);
        chk(req, 1'b0);
        @(posedge clk) rfi <= 1'b1;
        @(posedge clk) rfi <= 1'b0;
        wp(3'h1);
        rd(FL, 32'h0);
        pls(18'h40);
        @(posedge clk) ret <= 1'b1;
        @(posedge clk) ret <= 1'b0;
        @(negedge clk);
        chk(req, 1'b0);
        wr(CLR, 32'hFFFF);
    endtask
    task automatic t_grp();
        wr(EN, 32'h8090);
        pls(18'h1000);
        wp(3'h4);
        rd(FL, 32'h80);
        wr(EN, 32'h0);
        pls(18'h3_F000);
        rd(FL, 32'h1FF0);
        full <= 1'b1;
        wr(EN, 32'h8840);
        repeat (4) @(negedge clk);
        chk(req, 1'b0);
        @(posedge clk) full <= 1'b0;
        wp(3'h6);
        rd(FL, 32'h1FB0);
        wr(EN, 32'h0);
        wr(CLR, 32'hFFFF);
    endtask
    task automatic results();
        if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reg();
        t_base(itbu_pkg::ITBU_OFF_PSC0, 2'h0, itbu_pkg::ITBU_OFF_TBC0, 8'h80, 256);
        t_base(itbu_pkg::ITBU_OFF_PSC0, 2'h1, itbu_pkg::ITBU_OFF_TBC0, 8'h81, 2048);
        t_base(itbu_pkg::ITBU_OFF_PSC0, 2'h3, itbu_pkg::ITBU_OFF_TBC0, 8'h80, 3072);
        t_base(itbu_pkg::ITBU_OFF_PSC1, 2'h0, itbu_pkg::ITBU_OFF_TBC1, 8'h82, 1024);
        t_base(itbu_pkg::ITBU_OFF_PSC1, 2'h2, itbu_pkg::ITBU_OFF_TBC1, 8'h80, 3072);
        t_irq();
        t_grp();
        wk(18'h1_0000, 1'b1);
        wr(itbu_pkg::ITBU_OFF_FLAG_SET, 32'h1040);
        wk(18'h2_0000, 1'b0);
        rd(FL, 32'h1840);
        results();
    end
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule // itbu_top_test
